//--- logic/one_shot_ctrl.sv
// Controller end driving trigger, clear and width code of the one-shot
`timescale 1ns/1ps
`default_nettype none
module one_shot_ctrl (
  input  wire logic                              i_mclk,
  input  wire logic                              i_rst_n,
  input  wire logic                              i_start,
  input  wire logic [one_shot_pkg::CODE_W-1:0]   i_code,
  input  wire logic                              i_abort,
  output logic                                   o_ready,
  output logic                                   o_busy,
  one_shot_if.controller                         link
);
  import one_shot_pkg::*;

  // ****************************************
  // Drive and hold
  // ****************************************
  logic                  fire;
  logic                  clear;
  logic                  armed;
  logic                  pulse_seen;
  logic [CODE_W-1:0]     code;
  logic [STEP_W-1:0]     wait_cnt;

  // Gap counted after fall so the next trigger waits out the rearm time
  assign o_ready = armed && !fire && !clear && !link.pulse_out &&
                   (wait_cnt == STEP_RESET) && !pulse_seen;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fire       <= 1'b0;
      clear      <= 1'b1;
      armed      <= 1'b0;
      pulse_seen <= 1'b0;
      code       <= '0;
      wait_cnt   <= STEP_RESET;
      o_busy     <= 1'b0;
    end else begin
      clear <= i_abort;
      armed <= 1'b1;
      fire  <= 1'b0;
      if (i_abort) begin
        pulse_seen <= 1'b0;
        o_busy     <= 1'b0;
      end else if (o_ready && i_start) begin
        code   <= i_code;
        fire   <= 1'b1;
        o_busy <= 1'b1;
      end else if (link.pulse_out) begin
        pulse_seen <= 1'b1;
      end else if (pulse_seen) begin
        pulse_seen <= 1'b0;
        wait_cnt   <= STEP_W'(REARM_GAP_CYC + 1);
      end else if (wait_cnt != STEP_RESET) begin
        wait_cnt <= wait_cnt - STEP_W'(1);
        if (wait_cnt == STEP_W'(1)) o_busy <= 1'b0;
      end
    end
  end

  assign link.fire_input = fire;
  assign link.clear_line = clear;
  // Code is held from start until after the pulse falls
  assign link.width_code = code;
endmodule
`default_nettype wire

//--- logic/one_shot_gen.sv
// Programmable one-shot pulse generator, device end
//
// Notes on behaviour
// - Width is base plus code times step
// - Width grows monotonically across all codes
// - Step width fixed at build time
// - Trigger rising edge starts pulse after latency
// - Triggers ignored while pulse high
// - Rearm gap after pulse before new trigger
// - Clear high forces low and rearms
// - Controller holds code stable during pulse
// - Power-up may ignore triggers, then normal
// - Controller pulses clear at power-up
`timescale 1ns/1ps
`default_nettype none
module one_shot_gen (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  one_shot_if.generator                link
);
  import one_shot_pkg::*;

  // ****************************************
  // Trigger edge detect
  // ****************************************
  logic                 fire_prev;
  shot_state_t          state;
  shot_state_t          next_state;
  logic [CNT_W-1:0]     steps;
  logic [STEP_W-1:0]    sub;
  logic [STEP_W-1:0]    gap;
  logic                 fire_edge;
  logic                 base_done;
  logic                 step_end;
  logic                 in_base;
  logic                 pulse_end;

  assign fire_edge  = link.fire_input & ~fire_prev;
  assign step_end   = (sub == STEP_W'(STEP_CYC - 1));
  assign base_done  = (sub >= STEP_W'(BASE_CYC - 1));

  // ****************************************
  // Pulse sequencer
  // ****************************************
  // Base part counted first, then one step per code unit
  // Code is read live, not latched, so the controller must hold it
  // Zero code ends after base; otherwise after code full steps
  assign pulse_end = (state == ST_PULSE) &&
                     ((in_base && base_done && link.width_code == '0) ||
                      (!in_base && step_end &&
                       ({1'b0, link.width_code} <= steps + CNT_W'(1))));

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (fire_edge) next_state = ST_PULSE;
      ST_PULSE: if (pulse_end) next_state = ST_REARM;
      ST_REARM: if (gap >= STEP_W'(REARM_GAP_CYC - 1)) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || link.clear_line) begin
      state     <= ST_IDLE;
      fire_prev <= 1'b1;
      steps     <= CNT_RESET;
      sub       <= STEP_RESET;
      gap       <= STEP_RESET;
      in_base   <= 1'b1;
    end else begin
      fire_prev <= link.fire_input;
      state     <= next_state;
      case (state)
        ST_IDLE: begin
          sub     <= STEP_RESET;
          steps   <= CNT_RESET;
          in_base <= 1'b1;
          gap     <= STEP_RESET;
        end
        ST_PULSE: begin
          if (pulse_end) begin
            sub <= STEP_RESET;
          end else if (in_base) begin
            if (base_done) begin
              in_base <= 1'b0;
              sub     <= STEP_RESET;
            end else begin
              sub <= sub + STEP_W'(1);
            end
          end else if (step_end) begin
            sub   <= STEP_RESET;
            steps <= steps + CNT_W'(1);
          end else begin
            sub <= sub + STEP_W'(1);
          end
        end
        ST_REARM: begin
          gap <= gap + STEP_W'(1);
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Output follows state directly so clear drops it on the same edge
  assign link.pulse_out = (state == ST_PULSE);
endmodule
`default_nettype wire

//--- logic/one_shot_if.sv
// Link between the controller and the one-shot pulse generator
`timescale 1ns/1ps
`default_nettype none
interface one_shot_if;
  logic                                 fire_input;
  logic                                 clear_line;
  logic [one_shot_pkg::CODE_W-1:0]      width_code;
  logic                                 pulse_out;
  modport generator (input fire_input, input clear_line, input width_code,
                     output pulse_out);
  modport controller (output fire_input, output clear_line, output width_code,
                      input pulse_out);
endinterface
`default_nettype wire

//--- logic/one_shot_pkg.sv
// Shared constants for the programmable one-shot pulse generator and its controller
`default_nettype none
package one_shot_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned CODE_W           = 23;
  localparam int unsigned BASE_WIDTH_NS    = 100;
  localparam int unsigned STEP_WIDTH_NS    = 100;
  localparam int unsigned STEP_MIN_NS      = 20;
  localparam int unsigned STEP_MAX_NS      = 5000;
  localparam int unsigned FIRE_LATENCY_NS  = 10;
  localparam int unsigned REARM_GAP_NS     = 10;
  localparam int unsigned CLEAR_WIDTH_NS   = 10;
  // Least times round up, never below one cycle
  localparam int unsigned BASE_CYC =
    (BASE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CYC =
    (STEP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIRE_LATENCY_CYC =
    (FIRE_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REARM_GAP_CYC =
    (REARM_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_CYC =
    (CLEAR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W  = 24;
  localparam int unsigned STEP_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET  = 24'h000000;
  localparam logic [STEP_W-1:0] STEP_RESET = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PULSE = 3'b010,
    ST_REARM = 3'b100
  } shot_state_t;
endpackage
`default_nettype wire

//--- tb/one_shot_chk.sv
// Link checker for the one-shot pair
`timescale 1ns/1ps
`default_nettype none
module one_shot_chk (
  input wire logic                            i_mclk,
  input wire logic                            i_rst_n,
  input wire logic                            fire_input,
  input wire logic                            clear_line,
  input wire logic [one_shot_pkg::CODE_W-1:0] width_code,
  input wire logic                            pulse_out
);
  import one_shot_pkg::*;
  logic [CNT_W-1:0] hi_cnt;
  // A counter, as widths run far past any repetition bound
  always_ff @(posedge i_mclk) hi_cnt <= pulse_out ? hi_cnt + 1'b1 : '0;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    !fire_input ##1 (fire_input && !pulse_out && !$fell(pulse_out) && !clear_line);
  endsequence
  sequence s_end;
    $fell(pulse_out) && !$past(clear_line);
  endsequence
  a_fire_starts: assert property (s_take |=> pulse_out)
    else $error("pulse missed trigger");
  a_width_exact: assert property (s_end |->
    32'(hi_cnt) == BASE_CYC + 32'($past(width_code)) * STEP_CYC)
    else $error("pulse width off");
  a_rise_cause: assert property ($rose(pulse_out) |-> $past(fire_input) &&
    !$past(fire_input, 2) && !$past(clear_line))
    else $error("pulse without trigger edge");
  a_clear_drops: assert property (clear_line |=> !pulse_out)
    else $error("clear kept pulse");
  a_rearm_gap: assert property (s_end |=> !pulse_out)
    else $error("pulse in rearm gap");
  a_ctrl_spacing: assert property (s_end |-> !fire_input [*2])
    else $error("trigger in rearm gap");
  a_code_held: assert property (pulse_out && $past(pulse_out) |-> $stable(width_code))
    else $error("code moved in pulse");
  a_clear_at_boot: assert property ($rose(i_rst_n) |-> clear_line)
    else $error("no clear after reset");
endmodule
`default_nettype wire

//--- tb/programmable_one_shot_pulse_tb_top.sv
// Bench joining controller and generator over the link
`timescale 1ns/1ps
`default_nettype none
module programmable_one_shot_pulse_tb_top;
  import one_shot_pkg::*;
  typedef struct packed {logic [CODE_W-1:0] code; logic [31:0] width;} row_t;
  localparam row_t ROWS [5] = '{{23'h000000, 32'h1}, {23'h000001, 32'h2},
    {23'h000002, 32'h3}, {23'h000009, 32'ha}, {23'h0000ff, 32'h100}};
  logic              i_mclk;
  logic              i_rst_n;
  logic              i_start;
  logic [CODE_W-1:0] i_code;
  logic              i_abort;
  logic              o_ready;
  logic              o_busy;
  int                error_cnt = 0;
  int                samples_checked = 0;
  int                n;
  int                w;
  one_shot_if one_shot_if_i ();
  wire logic pulse = one_shot_if_i.pulse_out;
  wire logic clear = one_shot_if_i.clear_line;
  one_shot_gen one_shot_gen_i (.i_mclk, .i_rst_n, .link(one_shot_if_i));
  one_shot_ctrl one_shot_ctrl_i (.i_mclk, .i_rst_n, .i_start, .i_code, .i_abort,
    .o_ready, .o_busy, .link(one_shot_if_i));
  one_shot_chk one_shot_chk_i (.i_mclk, .i_rst_n, .fire_input(one_shot_if_i.fire_input),
    .clear_line(clear), .width_code(one_shot_if_i.width_code), .pulse_out(pulse));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One shot; abort requested after cut high cycles, n ends as seen width
  task automatic shot(input logic [CODE_W-1:0] c, input int cut);
    for (w = 0; o_ready !== 1'b1 && w < 99; w++) @(negedge i_mclk);
    i_start = 1'b1;
    i_code = c;
    @(negedge i_mclk);
    i_start = 1'b0;
    for (w = 0; pulse !== 1'b1 && w < 9; w++) @(negedge i_mclk);
    chk(o_busy, 1'b1);
    for (n = 0; pulse === 1'b1 && n < 400; n++) begin
      i_abort = (n == cut);
      @(negedge i_mclk);
    end
    i_abort = 1'b0;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (2000) @(posedge i_mclk);
    error_cnt++;
    test_done();
  end
  initial begin
    i_rst_n = 1'b0;
    i_start = 1'b0;
    i_code = '0;
    i_abort = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk(pulse, 1'b0);
    chk(clear, 1'b1);
    i_rst_n = 1'b1;
    // Short codes only: the full span would take millions of cycles
    foreach (ROWS[k]) begin
      shot(ROWS[k].code, 999);
      chk(w, FIRE_LATENCY_CYC);
      chk(n, ROWS[k].width);
    end
    shot(23'h000028, 5);
    chk(n, 32'h7);
    shot(23'h000003, 999);
    chk(n, 32'h4);
    chk(o_ready, 1'b0);
    repeat (REARM_GAP_CYC + 2) @(negedge i_mclk);
    chk(o_ready, 1'b1);
    chk(o_busy, 1'b0);
    // Reset in mid-pulse must drop the output and leave the unit usable
    i_start = 1'b1;
    i_code = 23'h000028;
    @(negedge i_mclk);
    i_start = 1'b0;
    repeat (4) @(negedge i_mclk);
    chk(pulse, 1'b1);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(pulse, 1'b0);
    chk(clear, 1'b1);
    chk(o_busy, 1'b0);
    i_rst_n = 1'b1;
    shot(23'h000001, 999);
    chk(n, 32'h2);
    test_done();
  end
endmodule
`default_nettype wire
